// ===== shared/rom_host_regs.svh
// Purpose: timing and field constants for the page-mode rom host controller
// Assumes: ref_clk at 100 MHz
// Notes: access times are the slower supply range figures
`ifndef ROM_HOST_REGS_SVH
`define ROM_HOST_REGS_SVH

`define ROM_CLK_NS 10
`define ROM_ACC_NS 100
`define ROM_PAGE_NS 25
`define ROM_DF_NS 25
`define ROM_WB_NS 100
`define ROM_CEIL_CYC(t) (((t) + `ROM_CLK_NS - 1) / `ROM_CLK_NS)
`define ROM_ACC_CYC `ROM_CEIL_CYC(`ROM_ACC_NS)
`define ROM_PAGE_CYC `ROM_CEIL_CYC(`ROM_PAGE_NS)
`define ROM_DF_CYC `ROM_CEIL_CYC(`ROM_DF_NS)
`define ROM_WB_CYC `ROM_CEIL_CYC(`ROM_WB_NS)
`define ROM_SYNC_LAT 3
`define ROM_WORD_ADDR_W 22
`define ROM_BYTE_ADDR_W 23
`define ROM_DATA_W 16
`define ROM_LOW_W 15
`define ROM_BYTE_W 8
`define ROM_PAGE_LSB_BYTE 3
`define ROM_PAGE_LSB_WORD 2
`define ROM_PAGE_W 20
`define ROM_CNT_W 8

`endif

// ===== shared/rom_host_pkg.sv
// Purpose: types shared by the rom host controller
// Assumes: nothing
// Notes: gate option is fixed per build
package rom_host_pkg;

  typedef enum logic [1:0] {
    gate_low_active = 2'b00,
    gate_high_active = 2'b01,
    gate_ignored = 2'b10
  } gate_mode_e;

  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_float = 2'b01,
    st_access = 2'b10
  } host_state_e;

endpackage

// ===== logic/pin_sync.sv
// Purpose: two flip-flop synchroniser for pin inputs
// Assumes: synchronous active high reset
// Notes: first stage feeds only the second
`timescale 1ns/1ps
module pin_sync #(
  parameter int unsigned WIDTH = 16
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // pin side
  input wire logic [WIDTH-1:0] din,
  // logic side
  output logic [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_dout;

  always_comb begin
    next_stage1 = din;
    next_dout = stage1;
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      stage1 <= '0;
      dout <= '0;
    end else begin
      stage1 <= next_stage1;
      dout <= next_dout;
    end
  end

endmodule // pin_sync

// ===== logic/page_rom_host.sv
// Purpose: host controller that reads a page-mode mask rom through its pins
// Assumes: ref_clk 100 MHz, rom has no clock, all rom outputs synchronised
// Notes: chip select is held between reads so page hits stay fast
`timescale 1ns/1ps
`include "rom_host_regs.svh"

// Operation
// - word mode: word_address carries the full 22-bit word address.
// - byte mode: word_address is upper 22 bits, lsb on shared pin.
// - shared pin is data bit 15 in word mode, host-driven lsb in byte mode.
// - page-only address changes with stable upper bits give data in 25 ns.
module page_rom_host
  import rom_host_pkg::*;
#(
  parameter gate_mode_e GATE_MODE = gate_low_active,
  parameter int unsigned ACC_CYCLES = `ROM_ACC_CYC,
  parameter int unsigned PAGE_CYCLES = `ROM_PAGE_CYC,
  parameter int unsigned DF_CYCLES = `ROM_DF_CYC,
  parameter int unsigned WB_CYCLES = `ROM_WB_CYC
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // read requests
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [`ROM_BYTE_ADDR_W-1:0] req_addr,
  input wire logic req_byte_mode,
  input wire logic standby_req,
  // read answers
  output logic rsp_valid,
  output logic [`ROM_DATA_W-1:0] rsp_data,
  // rom pins
  output logic [`ROM_WORD_ADDR_W-1:0] word_address,
  output logic width_select,
  output logic chip_select_n,
  output logic output_gate,
  input wire logic [`ROM_LOW_W-1:0] data_out_low,
  input wire logic data_bit15_in,
  output logic data_bit15_out,
  output logic data_bit15_oe
);

  // longest of full access and width switch, plus synchroniser latency
  localparam int unsigned FULL_WAIT =
    ((ACC_CYCLES > WB_CYCLES) ? ACC_CYCLES : WB_CYCLES) + `ROM_SYNC_LAT;
  localparam int unsigned PAGE_WAIT = PAGE_CYCLES + `ROM_SYNC_LAT;

  host_state_e state, next_state;
  logic [`ROM_CNT_W-1:0] count, next_count;
  logic [`ROM_WORD_ADDR_W-1:0] next_word_address;
  logic addr_lsb, next_addr_lsb;
  logic next_width_select;
  logic next_chip_select_n;
  logic gate_on, next_gate_on;
  logic next_rsp_valid;
  logic [`ROM_DATA_W-1:0] next_rsp_data;
  logic [`ROM_PAGE_W-1:0] cur_page, next_cur_page;
  logic page_ok, next_page_ok;
  logic mode_mismatch;
  logic page_hit;
  logic [`ROM_DATA_W-1:0] pins_synced;

  // page tag: byte address bits above the 8-byte page, or word bits above 4 words
  function automatic logic [`ROM_PAGE_W-1:0] page_of(
    input logic [`ROM_BYTE_ADDR_W-1:0] addr,
    input logic byte_mode
  );
    logic [`ROM_PAGE_W-1:0] tag;
    if (byte_mode) begin
      tag = addr[`ROM_BYTE_ADDR_W-1:`ROM_PAGE_LSB_BYTE];
    end else begin
      tag = addr[`ROM_WORD_ADDR_W-1:`ROM_PAGE_LSB_WORD];
    end
    return tag;
  endfunction

  pin_sync #(
    .WIDTH(`ROM_DATA_W)
  ) u_data_sync (
    .ref_clk(ref_clk),
    .reset(reset),
    .din({data_bit15_in, data_out_low}),
    .dout(pins_synced)
  );

  assign mode_mismatch = (req_byte_mode == width_select);
  assign page_hit = page_ok && (page_of(req_addr, req_byte_mode) == cur_page);
  assign req_ready = (state == st_idle) && !mode_mismatch;

  // shared pin is ours only in byte mode, and never while the rom may still drive it
  assign data_bit15_oe = !width_select && (state != st_float);
  assign data_bit15_out = addr_lsb;

  // polarity fixed at build time
  always_comb begin
    case (GATE_MODE)
      gate_low_active: output_gate = !gate_on;
      gate_high_active: output_gate = gate_on;
      default: output_gate = 1'b0;
    endcase
  end

  always_comb begin
    next_state = state;
    next_count = count;
    next_word_address = word_address;
    next_addr_lsb = addr_lsb;
    next_width_select = width_select;
    next_chip_select_n = chip_select_n;
    next_gate_on = gate_on;
    next_rsp_valid = 1'b0;
    next_rsp_data = rsp_data;
    next_cur_page = cur_page;
    next_page_ok = page_ok;
    case (state)
      st_idle: begin
        if (req_valid && mode_mismatch) begin
          // deselect first so the rom releases the shared pin
          next_state = st_float;
          next_chip_select_n = 1'b1;
          next_gate_on = 1'b0;
          next_width_select = !req_byte_mode;
          next_count = `ROM_CNT_W'(DF_CYCLES);
          next_page_ok = 1'b0;
        end else if (req_valid) begin
          if (req_byte_mode) begin
            next_word_address = req_addr[`ROM_BYTE_ADDR_W-1:1];
            next_addr_lsb = req_addr[0];
          end else begin
            next_word_address = req_addr[`ROM_WORD_ADDR_W-1:0];
            next_addr_lsb = 1'b0;
          end
          next_chip_select_n = 1'b0;
          next_gate_on = 1'b1;
          if (page_hit) begin
            next_count = `ROM_CNT_W'(PAGE_WAIT);
          end else begin
            next_count = `ROM_CNT_W'(FULL_WAIT);
          end
          next_cur_page = page_of(req_addr, req_byte_mode);
          next_page_ok = 1'b1;
          next_state = st_access;
        end else if (standby_req) begin
          next_chip_select_n = 1'b1;
          next_gate_on = 1'b0;
          next_page_ok = 1'b0;
        end
      end
      st_float: begin
        if (count <= `ROM_CNT_W'(1)) begin
          next_state = st_idle;
        end else begin
          next_count = count - `ROM_CNT_W'(1);
        end
      end
      st_access: begin
        if (count <= `ROM_CNT_W'(1)) begin
          next_rsp_valid = 1'b1;
          if (width_select) begin
            next_rsp_data = pins_synced;
          end else begin
            // upper outputs float in byte mode, so they are not read
            next_rsp_data = {`ROM_BYTE_W'(0), pins_synced[`ROM_BYTE_W-1:0]};
          end
          next_state = st_idle;
        end else begin
          next_count = count - `ROM_CNT_W'(1);
        end
      end
      default: begin
        next_state = st_idle;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state <= st_idle;
      count <= '0;
      word_address <= '0;
      addr_lsb <= 1'b0;
      width_select <= 1'b1;
      chip_select_n <= 1'b1;
      gate_on <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_data <= '0;
      cur_page <= '0;
      page_ok <= 1'b0;
    end else begin
      state <= next_state;
      count <= next_count;
      word_address <= next_word_address;
      addr_lsb <= next_addr_lsb;
      width_select <= next_width_select;
      chip_select_n <= next_chip_select_n;
      gate_on <= next_gate_on;
      rsp_valid <= next_rsp_valid;
      rsp_data <= next_rsp_data;
      cur_page <= next_cur_page;
      page_ok <= next_page_ok;
    end
  end

  // helper: cycles since a read was issued, and whether it was a page hit
  logic [`ROM_CNT_W-1:0] elapsed;
  logic last_hit;
  logic [`ROM_CNT_W-1:0] cs_high_cnt;
  int full_min;
  int page_min;
  assign full_min = FULL_WAIT;
  assign page_min = PAGE_WAIT;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      elapsed <= '0;
      last_hit <= 1'b0;
      cs_high_cnt <= '0;
    end else begin
      if (req_valid && req_ready) begin
        elapsed <= '0;
        last_hit <= page_hit;
      end else if (elapsed != '1) begin
        elapsed <= elapsed + `ROM_CNT_W'(1);
      end
      if (!chip_select_n) begin
        cs_high_cnt <= '0;
      end else if (cs_high_cnt != '1) begin
        cs_high_cnt <= cs_high_cnt + `ROM_CNT_W'(1);
      end
    end
  end

  sequence s_accept;
    req_valid && req_ready;
  endsequence

  sequence s_answer;
    ##[1:40] rsp_valid;
  endsequence

  a_word_addr_map: assert property (@(posedge ref_clk) disable iff (reset)
    (s_accept and !req_byte_mode) |=>
      word_address == $past(req_addr[`ROM_WORD_ADDR_W-1:0]))
    else $error("word address not driven from request");

  a_byte_addr_map: assert property (@(posedge ref_clk) disable iff (reset)
    (s_accept and req_byte_mode) |=>
      ({word_address, data_bit15_out} == $past(req_addr)) && data_bit15_oe)
    else $error("byte address not split onto pins");

  a_shared_pin_dir: assert property (@(posedge ref_clk) disable iff (reset)
    width_select |-> !data_bit15_oe)
    else $error("host drives shared pin in word mode");

  a_gate_level: assert property (@(posedge ref_clk) disable iff (reset)
    (state == st_access) |-> (output_gate == ((GATE_MODE == gate_low_active) ? 1'b0 :
      (GATE_MODE == gate_high_active) ? 1'b1 : 1'b0)) && !chip_select_n)
    else $error("output gate not active during access");

  a_full_wait: assert property (@(posedge ref_clk) disable iff (reset)
    (rsp_valid && !last_hit) |-> elapsed >= full_min[7:0])
    else $error("full access sampled too early");

  a_page_wait: assert property (@(posedge ref_clk) disable iff (reset)
    (rsp_valid && last_hit) |-> elapsed >= page_min[7:0] && elapsed < full_min[7:0])
    else $error("page access wait wrong");

  a_answer_bound: assert property (@(posedge ref_clk) disable iff (reset)
    s_accept |-> s_answer)
    else $error("no answer after accepted read");

  a_float_first: assert property (@(posedge ref_clk) disable iff (reset)
    $rose(data_bit15_oe) |-> cs_high_cnt >= DF_CYCLES[7:0])
    else $error("shared pin driven before rom floated");

  a_width_stable: assert property (@(posedge ref_clk) disable iff (reset)
    $changed(width_select) |-> chip_select_n)
    else $error("width changed while selected");

endmodule // page_rom_host

// ===== verification/rom_model.sv
// Purpose: behavioural page-mode rom as seen at its pins
// Assumes: 1 ns update step, slower supply range delays
// Notes: lines without valid data toggle so stale values never pass
`timescale 1ns/1ps
module rom_model
  import rom_host_pkg::*;
#(
  parameter gate_mode_e GATE_MODE = gate_low_active,
  parameter int ACC_NS = 100,
  parameter int PAGE_NS = 25,
  parameter int GATE_NS = 25
) (
  // address and control pins
  input wire logic [21:0] word_address,
  input wire logic width_select,
  input wire logic chip_select_n,
  input wire logic output_gate,
  input wire logic byte_lsb_address,
  // data pins
  output logic [14:0] data_out_low,
  output logic data_bit15,
  output logic data_bit15_oe
);
  realtime t_up = 0;
  realtime t_pg = 0;
  realtime t_cs = 0;
  realtime t_gate = 0;
  realtime t_wid = 0;
  logic [15:0] drv = 16'h0000;
  logic [15:0] word_v;
  logic [15:0] val;
  logic [15:0] mask;
  logic ok;
  logic gate_on;
  assign gate_on = (GATE_MODE == gate_ignored) ||
    (output_gate === (GATE_MODE == gate_high_active));
  always @(word_address[21:2]) t_up = $realtime;
  always @(word_address[1:0]) t_pg = $realtime;
  always @(byte_lsb_address) if (!width_select) t_pg = $realtime;
  always @(negedge chip_select_n) t_cs = $realtime;
  always @(posedge gate_on) t_gate = $realtime;
  always @(width_select) t_wid = $realtime;
  // no hold time: any late input spoils the data at once
  always #1 begin
    word_v = {word_address[7:0] ^ 8'h3c, word_address[15:8] ^ word_address[21:14]};
    val = width_select ? word_v : {8'h00, byte_lsb_address ? word_v[15:8] : word_v[7:0]};
    mask = width_select ? 16'hffff : 16'h00ff;
    ok = !chip_select_n && gate_on && $realtime >= t_up + ACC_NS &&
      $realtime >= t_cs + ACC_NS && $realtime >= t_gate + GATE_NS &&
      $realtime >= t_pg + PAGE_NS && $realtime >= t_wid + ACC_NS;
    drv = ok ? ((val & mask) | (~drv & ~mask)) : ~drv;
  end
  assign data_out_low = drv[14:0];
  assign data_bit15 = drv[15];
  assign data_bit15_oe = width_select && !chip_select_n && gate_on;
endmodule // rom_model

// ===== verification/testbench.sv
// Purpose: self-checking bench for the rom host, one lane per gate option
// Assumes: inputs driven at falling edge, rom_model on the pins
// Notes: undriven shared pin follows the clock, never a stale level
`timescale 1ns/1ps
module testbench
  import rom_host_pkg::*;
;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic req_valid = 1'b0;
  logic [22:0] req_addr = 23'h000000;
  logic req_byte_mode = 1'b0;
  logic standby_req = 1'b0;
  logic req_ready [3];
  logic rsp_valid [3];
  logic [15:0] rsp_data [3];
  logic [21:0] word_address [3];
  logic width_select [3];
  logic chip_select_n [3];
  logic output_gate [3];
  int err_count = 0;
  int checked = 0;

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask

  for (genvar g = 0; g < 3; g++) begin : lane
    logic [14:0] dlow;
    logic b15_in;
    logic b15_out;
    logic b15_oe;
    logic rom_b15;
    logic rom_oe;
    assign b15_in = b15_oe ? b15_out : (rom_oe ? rom_b15 : ref_clk);
    page_rom_host #(.GATE_MODE(gate_mode_e'(g))) dut_u (
      .ref_clk(ref_clk), .reset(reset), .req_valid(req_valid), .req_ready(req_ready[g]),
      .req_addr(req_addr), .req_byte_mode(req_byte_mode), .standby_req(standby_req),
      .rsp_valid(rsp_valid[g]), .rsp_data(rsp_data[g]), .word_address(word_address[g]),
      .width_select(width_select[g]), .chip_select_n(chip_select_n[g]),
      .output_gate(output_gate[g]), .data_out_low(dlow), .data_bit15_in(b15_in),
      .data_bit15_out(b15_out), .data_bit15_oe(b15_oe));
    rom_model #(.GATE_MODE(gate_mode_e'(g))) rom_u (
      .word_address(word_address[g]), .width_select(width_select[g]),
      .chip_select_n(chip_select_n[g]), .output_gate(output_gate[g]),
      .byte_lsb_address(b15_in), .data_out_low(dlow), .data_bit15(rom_b15),
      .data_bit15_oe(rom_oe));
    always @(negedge ref_clk) if (!reset) check("contention", {31'h0, b15_oe & rom_oe}, 32'h0);
  end

  function automatic logic [15:0] exp_word(input logic [21:0] a);
    return {a[7:0] ^ 8'h3c, a[15:8] ^ a[21:14]};
  endfunction

  // wait_n: refused cycles before taking; lat: cycles from taking edge to answer
  task automatic rd(input logic [22:0] a, input logic bm, input int wait_n, input int lat);
    int n;
    logic [15:0] w;
    logic [15:0] e;
    w = exp_word(bm ? a[22:1] : a[21:0]);
    e = bm ? {8'h00, a[0] ? w[15:8] : w[7:0]} : w;
    @(negedge ref_clk);
    req_valid = 1'b1;
    req_addr = a;
    req_byte_mode = bm;
    #1;
    n = 0;
    while (req_ready[0] !== 1'b1 && n < 40) begin
      @(negedge ref_clk);
      n++;
    end
    check("refused cycles", 32'(n), 32'(wait_n));
    @(negedge ref_clk);
    req_valid = 1'b0;
    // counted from the falling edge just after the taking edge
    n = 0;
    while (rsp_valid[0] !== 1'b1 && n < 40) begin
      @(negedge ref_clk);
      n++;
    end
    check("latency", 32'(n), 32'(lat));
    check("gate low option", {31'h0, output_gate[0]}, 32'h0);
    check("gate high option", {31'h0, output_gate[1]}, 32'h1);
    check("gate ignored option", {31'h0, output_gate[2]}, 32'h0);
    for (int i = 0; i < 3; i++) check("data", {16'h0, rsp_data[i]}, {16'h0, e});
  endtask

  task automatic t_word;
    rd(23'h0abcd4, 1'b0, 0, 13);
    rd(23'h0abcd7, 1'b0, 0, 6);
    rd(23'h0abcd5, 1'b0, 0, 6);
    rd(23'h0abcd8, 1'b0, 0, 13);
    rd(23'h2abcd9, 1'b0, 0, 13);
    $display("test word done");
  endtask

  task automatic t_byte;
    rd(23'h1579b8, 1'b1, 4, 13);
    check("width pin", {31'h0, width_select[0]}, 32'h0);
    check("lsb driven", {31'h0, lane[0].b15_oe}, 32'h1);
    rd(23'h1579bf, 1'b1, 0, 6);
    rd(23'h1579b9, 1'b1, 0, 6);
    rd(23'h1579c0, 1'b1, 0, 13);
    rd(23'h0abcd4, 1'b0, 4, 13);
    check("lsb released", {31'h0, lane[0].b15_oe}, 32'h0);
    $display("test byte done");
  endtask

  task automatic t_standby;
    int n;
    @(negedge ref_clk);
    standby_req = 1'b1;
    n = 0;
    while (chip_select_n[0] !== 1'b1 && n < 10) begin
      @(negedge ref_clk);
      n++;
    end
    check("standby select", {31'h0, chip_select_n[0]}, 32'h1);
    check("gate low idle", {31'h0, output_gate[0]}, 32'h1);
    check("gate high idle", {31'h0, output_gate[1]}, 32'h0);
    standby_req = 1'b0;
    // same page as before, but deselect must force the full access
    rd(23'h0abcd5, 1'b0, 0, 13);
    $display("test standby done");
  endtask

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    forever #5 ref_clk = ~ref_clk;
  end

  initial begin
    #50000;
    err_count++;
    test_done;
  end

  initial begin
    repeat (3) @(negedge ref_clk);
    check("reset select", {31'h0, chip_select_n[0]}, 32'h1);
    check("reset width", {31'h0, width_select[0]}, 32'h1);
    check("reset answer", {31'h0, rsp_valid[0]}, 32'h0);
    reset = 1'b0;
    t_word;
    t_byte;
    t_standby;
    test_done;
  end
endmodule // testbench
